// ### src/port_pin_mode_consts.svh
// Register indices, field positions, reset values and widths for the GPIO mode block.
`ifndef PORT_PIN_MODE_CONSTS_SVH
`define PORT_PIN_MODE_CONSTS_SVH

// Register indices; byte address is four times the index.
`define IDX_PORT0_DATA       8'h80
`define IDX_PORT1_DATA       8'h90
`define IDX_PORT2_DATA       8'hA0
`define IDX_PORT3_DATA       8'hB0
`define IDX_PORT4_DATA       8'hC0
`define IDX_PORT0_MODE_LOW   8'hD4
`define IDX_PORT0_MODE_HIGH  8'hD5
`define IDX_PORT1_MODE_LOW   8'hE6
`define IDX_PORT1_MODE_HIGH  8'hE7
`define IDX_PORT2_MODE_LOW   8'hD6
`define IDX_PORT2_MODE_HIGH  8'hD7
`define IDX_PORT3_MODE_LOW   8'hDE
`define IDX_PORT3_MODE_HIGH  8'hCF
`define IDX_PORT4_MODE_LOW   8'hBE
`define IDX_PORT4_MODE_HIGH  8'hBF
`define IDX_AUX_CTRL         8'h8E
`define IDX_CLK_MEM_CTRL     8'hF0
`define IDX_STATUS           8'hF1
`define IDX_PIN_STATE_BASE   8'hF8

// Auxiliary control: global very weak pull-up disable.
`define AUX_WPU_OFF_BIT      0
// Clock and memory control fields.
`define CMC_PRI_SRC_LSB      0
`define CMC_SEC_EN_BIT       2
`define CMC_EXT_PROG_BIT     3
`define CMC_EXT_DATA_BIT     4
`define CMC_WIDTH            5
`define CMC_RESET            5'h00
// Primary clock source encodings.
`define PRI_SRC_CRYSTAL      2'h0
`define PRI_SRC_EXT_CLOCK    2'h1
`define PRI_SRC_INT_RC       2'h2

// Mode register reset values.
`define RST_MODE_ALL         8'hFF
`define RST_MODE_NONE        8'h00
`define RST_P4_LOW_FUSE      8'hC7
`define RST_P4_LOW_NOFUSE    8'h03
`define RST_P4_HIGH          8'h03
`define RST_DATA             8'hFF

// Fixed pin positions in the flat 40-pin vector.
`define PIN_EXT_IRQ_ZERO     26
`define PIN_EXT_IRQ_ONE      27
`define PIN_CRYSTAL_IN       38
`define PIN_CRYSTAL_OUT      39
`define PIN_SEC_OSC_MASK     40'h00_0000_0100
`define PIN_EXT_PROG_MASK    40'h30_00FF_00FF
`define PIN_EXT_DATA_MASK    40'h00_C000_0000
`define PORT1_LSB            8

`define NUM_PORTS            5
`define PORT_WIDTH           8

`endif

// ### src/port_pin_mode_pkg.sv
// Types shared by the GPIO mode block and its bench.
`default_nettype none
package port_pin_mode_pkg;
    // Pin mode, in order of the two select bits {low, high}.
    typedef enum logic [1:0] {
        MODE_QUASI,
        MODE_PUSH_PULL,
        MODE_INPUT_ONLY,
        MODE_OPEN_DRAIN
    } pin_mode_e;

    // Per-pin pad controls, one bit per pin of the flat 40-pin vector.
    typedef struct packed {
        logic [39:0] drive_oe_n;
        logic [39:0] drive_val;
        logic [39:0] weak_pu;
        logic [39:0] very_weak_pu;
        logic [39:0] ibuf_en;
    } pin_drive_s;
endpackage : port_pin_mode_pkg
`default_nettype wire

// ### src/port_pin_mode_config.sv
// Five 8-bit GPIO ports with per-pin mode control behind an AXI4-Lite slave.
`include "port_pin_mode_consts.svh"
`default_nettype none

module port_pin_mode_config #(
    parameter int unsigned NPORT = `NUM_PORTS,
    parameter int unsigned PW    = `PORT_WIDTH
) (
    // Clock and reset.
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // AXI4-Lite write address and data.
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [9:0]                     s_axi_awaddr,
    input  wire logic [2:0]                     s_axi_awprot,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    // AXI4-Lite write response.
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    output logic [1:0]                          s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    input  wire logic [9:0]                     s_axi_araddr,
    input  wire logic [2:0]                     s_axi_arprot,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    // Core status on the same clock.
    input  wire logic                           power_down,
    input  wire logic [7:0]                     kbd_irq_enable,
    // Non-volatile tristate-default fuse level.
    input  wire logic                           tristate_fuse,
    // Pads.
    input  wire logic [39:0]                    pin_in,
    output port_pin_mode_pkg::pin_drive_s       pad
);
    import port_pin_mode_pkg::*;

    localparam int unsigned NPIN = NPORT * PW;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register index of each port's data and mode registers.
    localparam logic [7:0] IDX_DATA [NPORT] = '{`IDX_PORT0_DATA, `IDX_PORT1_DATA,
        `IDX_PORT2_DATA, `IDX_PORT3_DATA, `IDX_PORT4_DATA};
    localparam logic [7:0] IDX_MLOW [NPORT] = '{`IDX_PORT0_MODE_LOW, `IDX_PORT1_MODE_LOW,
        `IDX_PORT2_MODE_LOW, `IDX_PORT3_MODE_LOW, `IDX_PORT4_MODE_LOW};
    localparam logic [7:0] IDX_MHIGH [NPORT] = '{`IDX_PORT0_MODE_HIGH, `IDX_PORT1_MODE_HIGH,
        `IDX_PORT2_MODE_HIGH, `IDX_PORT3_MODE_HIGH, `IDX_PORT4_MODE_HIGH};

    // Count the ones of a pin mask.
    function automatic logic [5:0] count_ones(input logic [39:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 40; i++) begin
            n = n + {5'h00, v[i]};
        end
        return n;
    endfunction : count_ones

    // State.
    logic [PW-1:0]          data_q      [NPORT];
    logic [PW-1:0]          mode_low_q  [NPORT];
    logic [PW-1:0]          mode_high_q [NPORT];
    logic                   wpu_off_q;
    logic [`CMC_WIDTH-1:0]  cmc_q;
    logic                   fuse_meta_q;
    logic                   fuse_sync_q;
    logic [39:0]            pin_meta_q;
    logic [39:0]            pin_sync_q;
    logic [39:0]            latch_prev_q;
    logic [39:0]            avail_q;
    logic [5:0]             avail_cnt_q;
    logic                   aw_held_q;
    logic                   w_held_q;
    logic [7:0]             waddr_q;
    logic [7:0]             wbyte_q;
    logic                   wstrb0_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [31:0]            rdata_q;
    logic [1:0]             rresp_q;
    pin_drive_s             pad_q;

    // Flat views of the per-port registers.
    logic [39:0] latch_flat;
    logic [39:0] mlow_flat;
    logic [39:0] mhigh_flat;
    for (genvar p = 0; p < NPORT; p++) begin : g_flat
        assign latch_flat[p*PW +: PW] = data_q[p];
        assign mlow_flat[p*PW +: PW]  = mode_low_q[p];
        assign mhigh_flat[p*PW +: PW] = mode_high_q[p];
    end

    // Bus handshake decode; a write fires once both halves are held and no response is pending.
    // Each half is taken only on its own valid and ready, so nothing is taken in the
    // cycle after reset while the registered readies are still low.
    wire       aw_take   = s_axi_awvalid & s_axi_awready;
    wire       w_take    = s_axi_wvalid & s_axi_wready;
    wire       wr_fire   = aw_held_q & w_held_q & ~bvalid_q;
    wire       rd_take   = s_axi_arvalid & s_axi_arready;
    wire [7:0] raddr_idx = s_axi_araddr[9:2];
    wire       wr_lane   = wr_fire & wstrb0_q;

    // Write decode for the block's own registers.
    wire wr_aux = wr_lane & (waddr_q == `IDX_AUX_CTRL);
    wire wr_cmc = wr_lane & (waddr_q == `IDX_CLK_MEM_CTRL);
    logic [NPORT-1:0] wr_data;
    logic [NPORT-1:0] wr_mlow;
    logic [NPORT-1:0] wr_mhigh;
    logic [NPORT-1:0] hit_w_port;
    for (genvar p = 0; p < NPORT; p++) begin : g_wdec
        assign wr_data[p]    = wr_lane & (waddr_q == IDX_DATA[p]);
        assign wr_mlow[p]    = wr_lane & (waddr_q == IDX_MLOW[p]);
        assign wr_mhigh[p]   = wr_lane & (waddr_q == IDX_MHIGH[p]);
        assign hit_w_port[p] = (waddr_q == IDX_DATA[p]) | (waddr_q == IDX_MLOW[p])
                             | (waddr_q == IDX_MHIGH[p]);
    end
    wire wr_mapped = (|hit_w_port) | (waddr_q == `IDX_AUX_CTRL)
                   | (waddr_q == `IDX_CLK_MEM_CTRL) | (waddr_q == `IDX_STATUS);

    // Read decode; pin-state registers return the gated sensed level.
    logic [39:0] sensed;
    logic [7:0]  rd_port_val;
    logic        rd_port_hit;
    always_comb begin
        rd_port_val = 8'h00;
        rd_port_hit = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            if (raddr_idx == IDX_DATA[p]) begin
                rd_port_val = data_q[p];
                rd_port_hit = 1'b1;
            end
            if (raddr_idx == IDX_MLOW[p]) begin
                rd_port_val = mode_low_q[p];
                rd_port_hit = 1'b1;
            end
            if (raddr_idx == IDX_MHIGH[p]) begin
                rd_port_val = mode_high_q[p];
                rd_port_hit = 1'b1;
            end
            if (raddr_idx == `IDX_PIN_STATE_BASE + 8'(p)) begin
                rd_port_val = sensed[p*PW +: PW];
                rd_port_hit = 1'b1;
            end
        end
    end
    wire        rd_aux  = (raddr_idx == `IDX_AUX_CTRL);
    wire        rd_cmc  = (raddr_idx == `IDX_CLK_MEM_CTRL);
    wire        rd_stat = (raddr_idx == `IDX_STATUS);
    wire        rd_hit  = rd_port_hit | rd_aux | rd_cmc | rd_stat;
    wire [31:0] rd_val  = rd_port_hit ? {24'h000000, rd_port_val}
                        : rd_aux  ? {31'h00000000, wpu_off_q}
                        : rd_cmc  ? {27'h0000000, cmc_q}
                        : rd_stat ? {25'h0000000, fuse_sync_q, avail_cnt_q}
                        : 32'h00000000;

    // Fuse-dependent mode reset values.
    wire [7:0] rst_mid_low = fuse_sync_q ? `RST_MODE_ALL : `RST_MODE_NONE;
    wire [7:0] rst_p4_low  = fuse_sync_q ? `RST_P4_LOW_FUSE : `RST_P4_LOW_NOFUSE;

    // Fuse and pin synchronisers.
    always_ff @(posedge aclk) begin
        fuse_meta_q <= tristate_fuse;
        fuse_sync_q <= fuse_meta_q;
        pin_meta_q  <= pin_in;
        pin_sync_q  <= pin_meta_q;
    end

    // Port data and mode registers; reset picks values from the settled fuse.
    always_ff @(posedge aclk) begin
        for (int p = 0; p < NPORT; p++) begin
            if (!aresetn) begin
                data_q[p]      <= `RST_DATA;
                mode_high_q[p] <= (p == 0) ? `RST_MODE_ALL
                                : (p == 4) ? `RST_P4_HIGH : `RST_MODE_NONE;
                mode_low_q[p]  <= (p == 0) ? `RST_MODE_ALL
                                : (p == 4) ? rst_p4_low : rst_mid_low;
            end else begin
                if (wr_data[p]) data_q[p] <= wbyte_q;
                if (wr_mlow[p]) mode_low_q[p] <= wbyte_q;
                if (wr_mhigh[p]) mode_high_q[p] <= wbyte_q;
            end
        end
    end

    // Auxiliary and clock/memory control registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wpu_off_q <= 1'b0;
            cmc_q     <= `CMC_RESET;
        end else begin
            if (wr_aux) wpu_off_q <= wbyte_q[`AUX_WPU_OFF_BIT];
            if (wr_cmc) cmc_q <= wbyte_q[`CMC_WIDTH-1:0];
        end
    end

    // Pins claimed by oscillators and the external memory bus.
    wire [1:0]  pri_src = cmc_q[`CMC_PRI_SRC_LSB +: 2];
    logic [39:0] claimed;
    always_comb begin
        claimed = 40'h00_0000_0000;
        if (pri_src != `PRI_SRC_INT_RC) claimed[`PIN_CRYSTAL_IN] = 1'b1;
        if (pri_src == `PRI_SRC_CRYSTAL) claimed[`PIN_CRYSTAL_OUT] = 1'b1;
        if (cmc_q[`CMC_SEC_EN_BIT]) claimed = claimed | `PIN_SEC_OSC_MASK;
        if (cmc_q[`CMC_EXT_PROG_BIT]) claimed = claimed | `PIN_EXT_PROG_MASK;
        if (cmc_q[`CMC_EXT_DATA_BIT]) claimed = claimed | `PIN_EXT_DATA_MASK;
    end

    // Input buffers stay on in power-down only for wake-capable pins.
    logic [39:0] pd_keep;
    always_comb begin
        pd_keep = 40'h00_0000_0000;
        pd_keep[`PIN_EXT_IRQ_ZERO] = 1'b1;
        pd_keep[`PIN_EXT_IRQ_ONE]  = 1'b1;
        pd_keep[`PIN_CRYSTAL_IN]   = 1'b1;
        pd_keep[`PIN_CRYSTAL_OUT]  = 1'b1;
        pd_keep[`PORT1_LSB +: 8]   = kbd_irq_enable;
    end
    wire [39:0] ibuf_en = power_down ? pd_keep : {40{1'b1}};
    assign sensed = pin_sync_q & ibuf_en;

    // Per-pin driver decode from the mode and the output latch.
    pin_drive_s drive_d;
    always_comb begin
        drive_d = '0;
        drive_d.ibuf_en = ibuf_en;
        for (int i = 0; i < 40; i++) begin
            drive_d.drive_oe_n[i] = 1'b1;
            case (pin_mode_e'({mlow_flat[i], mhigh_flat[i]}))
                MODE_QUASI: begin
                    if (!latch_flat[i]) begin
                        drive_d.drive_oe_n[i] = 1'b0;
                    end else if (!latch_prev_q[i]) begin
                        drive_d.drive_oe_n[i] = 1'b0;
                        drive_d.drive_val[i]  = 1'b1;
                    end
                    drive_d.very_weak_pu[i] = latch_flat[i] & ~wpu_off_q;
                    drive_d.weak_pu[i]      = latch_flat[i] & pin_sync_q[i];
                end
                MODE_PUSH_PULL: begin
                    drive_d.drive_oe_n[i] = 1'b0;
                    drive_d.drive_val[i]  = latch_flat[i];
                end
                MODE_OPEN_DRAIN: begin
                    drive_d.drive_oe_n[i] = latch_flat[i];
                end
                MODE_INPUT_ONLY: begin
                    drive_d.drive_oe_n[i] = 1'b1;
                end
                default: begin
                    drive_d.drive_oe_n[i] = 1'b1;
                end
            endcase
            if (claimed[i]) begin
                drive_d.drive_oe_n[i]   = 1'b1;
                drive_d.drive_val[i]    = 1'b0;
                drive_d.weak_pu[i]      = 1'b0;
                drive_d.very_weak_pu[i] = 1'b0;
            end
        end
    end

    // Pad registers and pin availability.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_prev_q <= {40{1'b1}};
            pad_q        <= '{drive_oe_n: {40{1'b1}}, default: '0};
            avail_q      <= {40{1'b1}};
            avail_cnt_q  <= 6'h00;
        end else begin
            latch_prev_q <= latch_flat;
            pad_q        <= drive_d;
            avail_q      <= ~claimed;
            avail_cnt_q  <= count_ones(avail_q);
        end
    end
    assign pad = pad_q;

    // AXI4-Lite write channel: address and data taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            waddr_q   <= 8'h00;
            wbyte_q   <= 8'h00;
            wstrb0_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                waddr_q   <= s_axi_awaddr[9:2];
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wbyte_q  <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel: one read outstanding, answered the next cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Ready outputs are registered complements of the holding state.
    logic awready_q;
    logic wready_q;
    logic arready_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            awready_q <= ~(aw_held_q | aw_take) | wr_fire;
            wready_q  <= ~(w_held_q | w_take) | wr_fire;
            arready_q <= ~(rvalid_q | rd_take) | (rvalid_q & s_axi_rready);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_arready = arready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

endmodule : port_pin_mode_config
`default_nettype wire

// ### tb/port_pin_mode_checker.sv
// Concurrent checks on the port mode block's bus handshakes and pad controls.
`default_nettype none
module port_pin_mode_checker (
    // Clock and reset.
    input wire logic                        aclk,
    input wire logic                        aresetn,
    // Register bus.
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic [31:0]                 s_axi_rdata,
    // Core status and pads.
    input wire logic                        power_down,
    input wire logic [7:0]                  kbd_irq_enable,
    input wire logic [39:0]                 pin_in,
    input wire port_pin_mode_pkg::pin_drive_s pad
);
    import port_pin_mode_pkg::*;
    logic [39:0] keep_q;
    logic        pd_q;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Pins whose input must survive power-down, one cycle behind like the pads.
    always_ff @(posedge aclk) begin
        keep_q <= {2'b11, 10'h000, 2'b11, 10'h000, kbd_irq_enable, 8'h00};
        pd_q   <= power_down;
    end

    a_pd_input_gate: assert property (pd_q |-> (pad.ibuf_en & ~keep_q) == 40'h0)
        else $error("input buffer left on in power-down");
    a_low_no_pullup: assert property (((~pad.drive_oe_n & ~pad.drive_val)
        & (pad.weak_pu | pad.very_weak_pu)) == 40'h0) else $error("pull-up while driving low");
    a_weak_needs_high: assert property ((pad.weak_pu & ~($past(pin_in, 2)
        | $past(pin_in, 3) | $past(pin_in, 4))) == 40'h0) else $error("weak pull-up on low pin");
    a_reset_open_drain: assert property ($rose(aresetn) |-> ##1 (pad.drive_oe_n[7:0] == 8'hFF
        && pad.drive_oe_n[33:32] == 2'b11 && (pad.weak_pu[7:0] | pad.very_weak_pu[7:0]) == 8'h00))
        else $error("open-drain pins not released after reset");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule : port_pin_mode_checker

bind port_pin_mode_config port_pin_mode_checker u_checker (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .power_down,
    .kbd_irq_enable, .pin_in, .pad);
`default_nettype wire

// ### tb/port_ext_circuit.sv
// Behavioural model of the circuits wired to the forty port pins.
`default_nettype none
module port_ext_circuit (
    // Clock for the floating-pin pattern.
    input wire logic                          aclk,
    // Pad controls and external pull-down requests.
    input wire port_pin_mode_pkg::pin_drive_s pad,
    input wire logic [39:0]                   ext_low,
    // Sensed pin levels.
    output logic [39:0]                       pin_level
);
    import port_pin_mode_pkg::*;
    logic [39:0] float_q = 40'h55_5555_5555;

    // An undriven, unpulled pin wanders every cycle so no stale level is trusted.
    always @(posedge aclk) begin
        float_q <= ~float_q;
    end

    // Strong drive wins, then an external pull-down, then any pull-up.
    assign pin_level = (~pad.drive_oe_n & pad.drive_val) | (pad.drive_oe_n & ~ext_low
        & (pad.weak_pu | pad.very_weak_pu | float_q));
endmodule : port_ext_circuit
`default_nettype wire

// ### tb/port_pin_mode_config_tb.sv
// Self-checking bench for the port mode block: bus access, reset modes and pad behaviour.
`include "port_pin_mode_consts.svh"
`default_nettype none
module port_pin_mode_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import port_pin_mode_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, tristate_fuse = 1'b1, power_down = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [7:0]  kbd_irq_enable = 8'h00;
    logic [39:0] ext_low = 40'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [39:0] pin_in;
    pin_drive_s  pad;
    int          n_errors = 0, n_tests = 0, pulses = 0, p0;
    logic [7:0]  idx_t [10] = '{`IDX_PORT0_MODE_LOW, `IDX_PORT0_MODE_HIGH, `IDX_PORT1_MODE_LOW,
        `IDX_PORT1_MODE_HIGH, `IDX_PORT2_MODE_LOW, `IDX_PORT2_MODE_HIGH, `IDX_PORT3_MODE_LOW,
        `IDX_PORT3_MODE_HIGH, `IDX_PORT4_MODE_LOW, `IDX_PORT4_MODE_HIGH};
    logic [7:0]  fz1_t [10] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hC7, 8'h03};
    logic [7:0]  fz0_t [10] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03};
    logic [4:0]  cmc_t [6] = '{5'h02, 5'h06, 5'h01, 5'h0A, 5'h12, 5'h00};
    logic [5:0]  cnt_t [6] = '{6'h28, 6'h27, 6'h27, 6'h16, 6'h26, 6'h26};

    port_pin_mode_config DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'h1),
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .power_down, .kbd_irq_enable, .tristate_fuse, .pin_in, .pad);
    port_ext_circuit u_ext (.aclk, .pad, .ext_low, .pin_level(pin_in));

    // Free-running clock and a count of strong high drives on port two pin zero.
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        if (!pad.drive_oe_n[16] && pad.drive_val[16]) pulses <= pulses + 1;
    end

    task automatic conclude();
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic do_reset(input logic f);
        aresetn <= 1'b0;
        tristate_fuse <= f;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask : do_reset

    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk("write response", {38'h0, er}, {38'h0, s_axi_bresp});
    endtask : axi_wr

    task automatic rd_chk(input logic [7:0] idx, input logic [1:0] er, input logic [7:0] ed);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk("read", {30'h0, er, ed}, {30'h0, s_axi_rresp, s_axi_rdata[7:0]});
    endtask : rd_chk

    task automatic pads2(input logic [31:0] e);
        logic [7:0] oe;
        oe = pad.drive_oe_n[23:16];
        chk("port2 pads", {8'h00, e}, {8'h00, oe, pad.drive_val[23:16] & ~oe,
            pad.very_weak_pu[23:16], pad.weak_pu[23:16]});
    endtask : pads2

    // Reset under both fuse levels, then modes, pull-ups, pin count and power-down.
    initial begin
        do_reset(1'b1);
        chk("reset pull-ups", {10'h0, 6'h38, 24'h0}, {10'h0, pad.very_weak_pu[37:8]});
        for (int i = 0; i < 10; i++) begin
            rd_chk(idx_t[i], 2'h0, fz1_t[i]);
            axi_wr(idx_t[i], idx_t[i] ^ 8'hA5, 2'h0);
            rd_chk(idx_t[i], 2'h0, idx_t[i] ^ 8'hA5);
        end
        rd_chk(8'h81, 2'h2, 8'h00);
        axi_wr(8'h81, 8'hFF, 2'h2);
        do_reset(1'b0);
        chk("reset pull-ups", {10'h0, 6'h3C, 24'hFFFFFF}, {10'h0, pad.very_weak_pu[37:8]});
        for (int i = 0; i < 10; i++) begin
            rd_chk(idx_t[i], 2'h0, fz0_t[i]);
        end
        axi_wr(`IDX_PORT2_MODE_LOW, 8'hF0, 2'h0);
        axi_wr(`IDX_PORT2_MODE_HIGH, 8'hCC, 2'h0);
        axi_wr(`IDX_PORT2_DATA, 8'h00, 2'h0);
        repeat (6) @(posedge aclk);
        pads2(32'h3000_0000);
        p0 = pulses;
        axi_wr(`IDX_PORT2_DATA, 8'hFF, 2'h0);
        repeat (6) @(posedge aclk);
        chk("strong pulses", 40'h1, 40'(pulses - p0));
        pads2(32'hF30C_0303);
        axi_wr(`IDX_AUX_CTRL, 8'h01, 2'h0);
        ext_low <= 40'h00_0002_0000;
        repeat (8) @(posedge aclk);
        pads2(32'hF30C_0001);
        for (int i = 0; i < 6; i++) begin
            axi_wr(`IDX_CLK_MEM_CTRL, {3'h0, cmc_t[i]}, 2'h0);
            repeat (3) @(posedge aclk);
            rd_chk(`IDX_STATUS, 2'h0, {2'h0, cnt_t[i]});
        end
        kbd_irq_enable <= 8'h01;
        power_down <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("wake inputs", 40'h301, {30'h0, pad.ibuf_en[27:26], pad.ibuf_en[15:8]});
        rd_chk(`IDX_PIN_STATE_BASE + 8'h03, 2'h0, 8'h0C);
        power_down <= 1'b0;
        repeat (3) @(posedge aclk);
        conclude();
    end

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        conclude();
    end
endmodule : port_pin_mode_config_tb
`default_nettype wire
